// [ctrc_pkg.sv]
// Purpose: constants for the charge timer and recharge configuration bank
// Assumes: byte-wide register port, 250 MHz system clock
// Notes: 11-bit boost voltage register occupies two consecutive byte addresses, low byte first
package ctrc_pkg;
  localparam logic [7:0] OFS_RECHG = 8'h0a;
  localparam logic [7:0] OFS_BOOSTV_LO = 8'h0b;
  localparam logic [7:0] OFS_BOOSTV_HI = 8'h0c;
  localparam logic [7:0] OFS_BOOSTI = 8'h0d;
  localparam logic [7:0] OFS_TMR = 8'h0e;
  localparam logic [7:0] OFS_REGRST = 8'h09;
  localparam int REGRST_BIT = 6;
  // status register holding timer fault flag
  localparam logic [7:0] OFS_FAULT = 8'h20;
  localparam logic [1:0] RST_DEGLITCH = 2'h2;
  localparam logic [3:0] RST_DROP = 4'h3;
  localparam logic [10:0] RST_BOOSTV = 11'h0dc;
  localparam logic [10:0] BOOSTV_MAX = 11'h780;
  localparam logic [6:0] RST_BOOSTI = 7'h4b;
  localparam logic [6:0] BOOSTI_MIN = 7'h03;
  localparam logic [7:0] RST_TMR = 8'h3d;
  localparam int CLK_MHZ = 250;
  localparam int MS_PER_MIN = 60000;
  localparam logic [15:0] MIN_PER_HR = 16'h003c;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000;
  localparam logic [15:0] TOPOFF_STEP_MIN = 16'h000f;
  localparam logic [15:0] PRE_LONG_MIN = 16'h0078;
  localparam logic [15:0] PRE_SHORT_MIN = 16'h001e;
  localparam logic [15:0] TRICKLE_MIN = 16'h003c;
  typedef enum logic [1:0] {CTRC_IDLE, CTRC_TRICKLE, CTRC_PRE, CTRC_FAST} ctrc_phase_t;
endpackage

// [ctrc_tick.sv]
// Purpose: divider producing one-cycle enables every millisecond and every minute
// Assumes: halve input slows counting to every other millisecond
// Notes: clear restarts both counts
`timescale 1ns/10ps
`default_nettype none
module ctrc_tick
  import ctrc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MIN_TICKS = MS_PER_MIN
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic halve,
  output logic ms_tick,
  output logic min_tick
);
  logic [31:0] cyc_q;
  logic [31:0] ms_q;
  logic odd_q;
  wire cyc_done = (cyc_q == 32'(TICK_CYCLES - 1));
  wire ms_step = cyc_done && (!halve || odd_q);
  wire ms_done = ms_step && (ms_q == 32'(MIN_TICKS - 1));
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      cyc_q <= '0;
      ms_q <= '0;
      odd_q <= 1'b0;
      ms_tick <= 1'b0;
      min_tick <= 1'b0;
    end
    else if (clear)
    begin
      cyc_q <= '0;
      ms_q <= '0;
      odd_q <= 1'b0;
      ms_tick <= 1'b0;
      min_tick <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_done ? '0 : cyc_q + 32'h1;
      odd_q <= cyc_done ? ~odd_q : odd_q;
      ms_tick <= cyc_done;
      min_tick <= ms_done;
      if (ms_step)
        ms_q <= ms_done ? '0 : ms_q + 32'h1;
    end
endmodule
`default_nettype wire

// [ctrc_top.sv]
// Purpose: recharge, boost limit and safety timer configuration bank
// Assumes: simple byte register port fed by the serial interface logic
// Notes: watchdog expiry arrives as a one-cycle pulse from logic on clk_sys
// Functional notes
// RL1 - at power-on the strap sense sets the 2-bit cell count, 0 one cell to 3 four cells.
// RL2 - recharge deglitch code 0..3 picks 64, 256, 1024 or 2048 ms, default code 2.
// RL3 - recharge offset is 50 mV plus 50 mV per code below the target, default code 3.
// RL4 - deglitch and offset reset on watchdog or register reset; cell count does not.
// RL5 - boost voltage is 2800 mV plus 10 mV per code, clamped high, default 0xdc.
// RL6 - boost current is 40 mA per code, clamped up to 120 mA, default 0x4b.
// RL7 - pre-charge timer is 2 h when clear and 0.5 h when set, reset on watchdog or reset.
// RL8 - top-off code 0 disables, 1..3 give 15, 30 or 45 minutes.
// RL9 - trickle timer enable switches a fixed one-hour timer, default on.
// RL10 - separate enables switch the pre-charge and fast timers, both default on.
// RL11 - fast timer code 0..3 gives 5, 8, 12 or 24 hours, default code 2.
// RL12 - with half-speed set, timers count at half rate during power limiting or thermal loop.
// RL13 - writing 1 to the register-reset bit restores defaults and restarts the safety timer.
// RL14 - an enabled timer expiring stops charging and raises a fault flag readable by the host.
`timescale 1ns/10ps
`default_nettype none
module ctrc_top
  import ctrc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MIN_TICKS = MS_PER_MIN
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic watchdog_expired,
  input wire logic [1:0] strap_resistor_pin,
  input wire logic input_power_limiting,
  input wire logic thermal_regulation,
  input wire logic [1:0] charge_phase_req,
  output logic [1:0] cell_count,
  output logic [1:0] recharge_deglitch_sel,
  output logic [3:0] recharge_drop_offset,
  output logic [10:0] boost_out_voltage_target,
  output logic [6:0] boost_out_current_cap,
  output logic [1:0] topoff_duration,
  output logic charge_allowed,
  output logic timer_fault
);
  function automatic logic [15:0] fast_minutes(input logic [1:0] code);
    unique case (code)
      2'h0: fast_minutes = 16'h0005 * MIN_PER_HR;
      2'h1: fast_minutes = 16'h0008 * MIN_PER_HR;
      2'h2: fast_minutes = 16'h000c * MIN_PER_HR;
      2'h3: fast_minutes = 16'h0018 * MIN_PER_HR;
    endcase
  endfunction

  logic [1:0] strap_s1_q, strap_s2_q, strap_s3_q;
  logic strap_done_q;
  logic [2:0] strap_vld_q;
  logic [1:0] cell_q;
  logic [1:0] deglitch_q;
  logic [3:0] drop_q;
  logic [10:0] boostv_q;
  logic [6:0] boosti_q;
  logic pretmr_q;
  logic [7:0] tmr_q;
  logic fault_q;
  logic [15:0] min_q;
  logic [1:0] phase_q;
  logic min_tick;
  ctrc_phase_t phase_now;

  wire regrst_wr = wr_en && addr == OFS_REGRST && wdata[REGRST_BIT];
  wire cfg_reset = watchdog_expired || regrst_wr; // RL4
  wire half_active = tmr_q[0] && (input_power_limiting || thermal_regulation); // RL12
  wire phase_change = charge_phase_req != phase_q;
  wire tmr_restart = regrst_wr || phase_change; // RL13
  assign phase_now = ctrc_phase_t'(phase_q);
  wire topoff_on = tmr_q[7:6] != 2'h0; // RL8
  wire fault_clear = wr_en && addr == OFS_FAULT;

  logic [15:0] limit_min;
  logic limit_on;
  always_comb
  begin
    limit_min = 16'hffff;
    limit_on = 1'b0;
    unique case (phase_now)
      CTRC_IDLE:
      begin
        limit_min = 16'hffff;
        limit_on = 1'b0;
      end
      CTRC_TRICKLE:
      begin
        limit_min = TRICKLE_MIN; // RL9
        limit_on = tmr_q[5];
      end
      CTRC_PRE:
      begin
        limit_min = pretmr_q ? PRE_SHORT_MIN : PRE_LONG_MIN; // RL7
        limit_on = tmr_q[4]; // RL10
      end
      CTRC_FAST:
      begin
        limit_min = fast_minutes(tmr_q[2:1]); // RL11
        limit_on = tmr_q[3]; // RL10
      end
    endcase
  end
  wire expire = limit_on && min_tick && (min_q + 16'h1 >= limit_min);

  ctrc_tick #(
    .TICK_CYCLES(TICK_CYCLES),
    .MIN_TICKS(MIN_TICKS)
  ) u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(tmr_restart),
    .halve(half_active),
    .ms_tick(),
    .min_tick(min_tick)
  );

  // strap is an outside level, so it passes three stages before it is caught
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      strap_s3_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_vld_q <= 3'h0;
      cell_q <= 2'h0;
    end
    else
    begin
      strap_s1_q <= strap_resistor_pin;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      strap_vld_q <= {strap_vld_q[1:0], 1'b1};
      // wait for a real sample in the last stage, else reset zeros pass as the strap
      if (!strap_done_q && strap_vld_q[2] && strap_s2_q == strap_s3_q)
      begin
        cell_q <= strap_s3_q; // RL1
        strap_done_q <= 1'b1;
      end
      else if (wr_en && addr == OFS_RECHG)
        cell_q <= wdata[7:6];
    end

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      deglitch_q <= RST_DEGLITCH;
      drop_q <= RST_DROP;
      boostv_q <= RST_BOOSTV;
      boosti_q <= RST_BOOSTI;
      pretmr_q <= 1'b0;
      tmr_q <= RST_TMR;
    end
    else if (cfg_reset)
    begin
      deglitch_q <= RST_DEGLITCH; // RL2
      drop_q <= RST_DROP; // RL3
      boostv_q <= RST_BOOSTV; // RL5
      boosti_q <= RST_BOOSTI; // RL6
      pretmr_q <= 1'b0; // RL7
      tmr_q <= RST_TMR; // RL13
    end
    else if (wr_en)
    begin
      if (addr == OFS_RECHG)
      begin
        deglitch_q <= wdata[5:4];
        drop_q <= wdata[3:0];
      end
      if (addr == OFS_BOOSTV_LO)
        boostv_q[7:0] <= wdata;
      if (addr == OFS_BOOSTV_HI)
        boostv_q[10:8] <= wdata[2:0];
      if (addr == OFS_BOOSTI)
      begin
        pretmr_q <= wdata[7];
        boosti_q <= wdata[6:0];
      end
      if (addr == OFS_TMR)
        tmr_q <= wdata;
    end

  // timer state; a fault set in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      min_q <= 16'h0;
      phase_q <= 2'h0;
      fault_q <= 1'b0;
    end
    else
    begin
      phase_q <= charge_phase_req;
      if (tmr_restart)
        min_q <= 16'h0;
      else if (min_tick && min_q != 16'hffff)
        min_q <= min_q + 16'h1;
      if (expire)
        fault_q <= 1'b1; // RL14
      else if (fault_clear || regrst_wr)
        fault_q <= 1'b0;
    end

  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (addr)
      OFS_RECHG: rd_mux = {cell_q, deglitch_q, drop_q};
      OFS_BOOSTV_LO: rd_mux = boostv_q[7:0];
      OFS_BOOSTV_HI: rd_mux = {5'h00, boostv_q[10:8]}; // RL5
      OFS_BOOSTI: rd_mux = {pretmr_q, boosti_q};
      OFS_TMR: rd_mux = tmr_q;
      OFS_FAULT: rd_mux = {7'h00, fault_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
    begin
      rdata <= 8'h00;
      cell_count <= 2'h0;
      recharge_deglitch_sel <= RST_DEGLITCH;
      recharge_drop_offset <= RST_DROP;
      boost_out_voltage_target <= RST_BOOSTV;
      boost_out_current_cap <= RST_BOOSTI;
      topoff_duration <= 2'h0;
      charge_allowed <= 1'b1;
      timer_fault <= 1'b0;
    end
    else
    begin
      if (rd_en)
        rdata <= rd_mux;
      cell_count <= cell_q;
      recharge_deglitch_sel <= deglitch_q;
      recharge_drop_offset <= drop_q;
      boost_out_voltage_target <= (boostv_q > BOOSTV_MAX) ? BOOSTV_MAX : boostv_q; // RL5
      boost_out_current_cap <= (boosti_q < BOOSTI_MIN) ? BOOSTI_MIN : boosti_q; // RL6
      topoff_duration <= topoff_on ? tmr_q[7:6] : 2'h0;
      charge_allowed <= !fault_q; // RL14
      timer_fault <= fault_q;
    end
endmodule
`default_nettype wire

// [ctrc_top_monitor.sv]
// Purpose: port assertions for ctrc_top
// Assumes: one clock domain, async high reset
// Notes: a taken write shows on the outputs two edges later
`timescale 1ns/10ps
`default_nettype none
module ctrc_top_monitor
  import ctrc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MIN_TICKS = MS_PER_MIN
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic watchdog_expired,
  input wire logic [1:0] strap_resistor_pin,
  input wire logic input_power_limiting,
  input wire logic thermal_regulation,
  input wire logic [1:0] charge_phase_req,
  input wire logic [1:0] cell_count,
  input wire logic [1:0] recharge_deglitch_sel,
  input wire logic [3:0] recharge_drop_offset,
  input wire logic [10:0] boost_out_voltage_target,
  input wire logic [6:0] boost_out_current_cap,
  input wire logic [1:0] topoff_duration,
  input wire logic charge_allowed,
  input wire logic timer_fault
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_wdog_recharge: assert property (watchdog_expired ##1 !wr_en |-> ##1
    recharge_deglitch_sel == RST_DEGLITCH && recharge_drop_offset == RST_DROP)
    else $error("watchdog left recharge fields");
  chk_wdog_boost: assert property (watchdog_expired ##1 !wr_en |-> ##1
    boost_out_voltage_target == RST_BOOSTV && boost_out_current_cap == RST_BOOSTI
    && topoff_duration == 2'h0) else $error("watchdog left boost fields");
  chk_boostv_clamp: assert property (boost_out_voltage_target <= BOOSTV_MAX)
    else $error("boost voltage above clamp");
  chk_boosti_floor: assert property (boost_out_current_cap >= BOOSTI_MIN)
    else $error("boost current below floor");
  chk_write_recharge: assert property (wr_en && addr == OFS_RECHG && !watchdog_expired
    ##1 !wr_en && !watchdog_expired |-> ##1
    {2'h0, recharge_deglitch_sel, recharge_drop_offset} == ($past(wdata, 2) & 8'h3f))
    else $error("recharge write not applied");
  chk_write_topoff: assert property (wr_en && addr == OFS_TMR && !watchdog_expired
    ##1 !wr_en && !watchdog_expired |-> ##1
    {topoff_duration, 6'h00} == ($past(wdata, 2) & 8'hc0)) else $error("topoff write lost");
  chk_regrst_dflt: assert property (wr_en && addr == OFS_REGRST && wdata[REGRST_BIT]
    ##1 !wr_en |-> ##1 !timer_fault && topoff_duration == 2'h0
    && boost_out_current_cap == RST_BOOSTI) else $error("register reset incomplete");
  chk_fault_stops: assert property (charge_allowed == !timer_fault)
    else $error("charge allowed during fault");
  chk_boostv_resvd: assert property (rd_en && addr == OFS_BOOSTV_HI |=> rdata[7:3] == 5'h00)
    else $error("reserved boost bits not zero");
  chk_unmapped_read: assert property (rd_en && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind ctrc_top ctrc_top_monitor #(.TICK_CYCLES(TICK_CYCLES), .MIN_TICKS(MIN_TICKS)) u_mon (
  .clk_sys, .sys_rst, .wr_en, .rd_en, .addr, .wdata, .rdata, .watchdog_expired,
  .strap_resistor_pin, .input_power_limiting, .thermal_regulation, .charge_phase_req,
  .cell_count, .recharge_deglitch_sel, .recharge_drop_offset, .boost_out_voltage_target,
  .boost_out_current_cap, .topoff_duration, .charge_allowed, .timer_fault);
`default_nettype wire

// [ctrc_host_model.sv]
// Purpose: host side of the byte register port
// Assumes: requests launch just after a rising edge
// Notes: idle address and data show the inverse so stale values never match
`timescale 1ns/10ps
`default_nettype none
module ctrc_host_model
  import ctrc_pkg::*;
(
  input wire logic clk_sys,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    addr <= ~a;
    @(negedge clk_sys);
    d = rdata;
  endtask
  task automatic reg_reset();
    wr(OFS_REGRST, 8'h40);
  endtask
endmodule
`default_nettype wire

// [test_charge_timer_recharge_config.sv]
// Purpose: self-checking bench for ctrc_top
// Assumes: shortened tick parameters, one minute is six cycles
// Notes: timer limits checked with a five minute margin either side
`timescale 1ns/10ps
`default_nettype none
module test_charge_timer_recharge_config;
  import ctrc_pkg::*;
  localparam int MIN_CYC = 6;
  logic clk_sys, sys_rst, watchdog_expired, input_power_limiting, thermal_regulation;
  logic wr_en, rd_en, charge_allowed, timer_fault;
  logic [7:0] addr, wdata, rdata, rv;
  logic [1:0] strap_resistor_pin, charge_phase_req, cell_count, recharge_deglitch_sel;
  logic [1:0] topoff_duration;
  logic [3:0] recharge_drop_offset;
  logic [10:0] boost_out_voltage_target;
  logic [6:0] boost_out_current_cap;
  logic [31:0] v;
  integer seed = 59;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] t0e [11] = '{8'h3d, 8'h3d, 8'h39, 8'h7b, 8'hbd, 8'hff, 8'h3d, 8'h3d, 8'h3c,
    8'h1d, 8'h2d};
  logic [1:0] tph [11] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
  int tlim [11] = '{30, 120, 300, 480, 720, 1440, 60, 120, 60, -1, -1};
  ctrc_top #(.TICK_CYCLES(2), .MIN_TICKS(3)) i_ctrc_top (.clk_sys, .sys_rst, .wr_en, .rd_en,
    .addr, .wdata, .rdata, .watchdog_expired, .strap_resistor_pin, .input_power_limiting,
    .thermal_regulation, .charge_phase_req, .cell_count, .recharge_deglitch_sel,
    .recharge_drop_offset, .boost_out_voltage_target, .boost_out_current_cap,
    .topoff_duration, .charge_allowed, .timer_fault);
  ctrc_host_model host (.clk_sys, .wr_en, .rd_en, .addr, .wdata, .rdata);
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk("rdata", {3'h0, e}, {3'h0, rv});
  endtask
  task automatic dflt(input logic [1:0] c);
    rdchk(OFS_RECHG, {c, RST_DEGLITCH, RST_DROP});
    rdchk(OFS_BOOSTV_LO, RST_BOOSTV[7:0]);
    rdchk(OFS_BOOSTI, {1'b0, RST_BOOSTI});
    rdchk(OFS_TMR, RST_TMR);
  endtask
  task automatic tmr_case(input int i);
    int n;
    host.wr(OFS_BOOSTI, i == 0 ? 8'h80 : 8'h4b);
    host.wr(OFS_TMR, t0e[i]);
    @(posedge clk_sys);
    input_power_limiting <= (i == 7);
    thermal_regulation <= (i == 8);
    charge_phase_req <= 2'h0;
    host.wr(OFS_FAULT, 8'h00);
    @(posedge clk_sys);
    charge_phase_req <= tph[i];
    repeat ((tlim[i] < 0 ? 200 : tlim[i] - 5) * MIN_CYC) @(posedge clk_sys);
    chk("fault_early", 11'h0, {10'h0, timer_fault});
    if (tlim[i] >= 0)
    begin
      n = 0;
      while (timer_fault !== 1'b1 && n < 10 * MIN_CYC)
      begin
        @(posedge clk_sys);
        n++;
      end
      chk("fault_late", 11'h1, {10'h0, timer_fault});
      chk("charge_allowed", 11'h0, {10'h0, charge_allowed});
      rdchk(OFS_FAULT, 8'h01);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [10:0] boostv_exp(input logic [10:0] c);
    return (c > BOOSTV_MAX) ? BOOSTV_MAX : c;
  endfunction
  function automatic logic [10:0] boosti_exp(input logic [6:0] c);
    return {4'h0, (c < BOOSTI_MIN) ? BOOSTI_MIN : c};
  endfunction
  initial
  begin
    sys_rst = 1'b1;
    watchdog_expired = 1'b0;
    input_power_limiting = 1'b0;
    thermal_regulation = 1'b0;
    charge_phase_req = 2'h0;
    strap_resistor_pin = 2'($random(seed));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("cell", {9'h0, strap_resistor_pin}, {9'h0, cell_count});
    dflt(strap_resistor_pin);
    rdchk(OFS_BOOSTV_HI, 8'h00);
    rdchk(8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      if (i == 0)
        v[30:8] = 23'h0007ff;
      host.wr(OFS_RECHG, {v[7:6], 2'(i), v[3:0]});
      host.wr(OFS_BOOSTV_LO, v[15:8]);
      host.wr(OFS_BOOSTV_HI, v[23:16]);
      host.wr(OFS_BOOSTI, v[31:24]);
      repeat (2) @(posedge clk_sys);
      chk("boost_v", boostv_exp(v[18:8]), boost_out_voltage_target);
      chk("boost_i", boosti_exp(v[30:24]), {4'h0, boost_out_current_cap});
      chk("deglitch", 11'(i), {9'h0, recharge_deglitch_sel});
      chk("offset", {7'h0, v[3:0]}, {7'h0, recharge_drop_offset});
      rdchk(OFS_BOOSTV_HI, {5'h00, v[18:16]});
      rdchk(OFS_RECHG, {v[7:6], 2'(i), v[3:0]});
    end
    v = $random(seed);
    host.wr(OFS_RECHG, v[7:0]);
    host.wr(OFS_TMR, 8'hc2);
    @(posedge clk_sys);
    watchdog_expired <= 1'b1;
    @(posedge clk_sys);
    watchdog_expired <= 1'b0;
    dflt(v[7:6]);
    chk("cell", {9'h0, v[7:6]}, {9'h0, cell_count});
    host.wr(OFS_RECHG, ~v[7:0]);
    host.wr(OFS_BOOSTI, 8'h85);
    host.reg_reset();
    dflt(~v[7:6]);
    for (int i = 0; i < 11; i++)
      tmr_case(i);
    summarize();
  end
endmodule
`default_nettype wire
